// File: pin_route_pkg.sv
// Shared constants and types for the port pull and PWM routing block.
package pin_route_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [11:0] PULL_EN_OFFSET = 12'h000;
    localparam logic [11:0] POLARITY_OFFSET = 12'h004;
    localparam logic [11:0] ROUTE_HIGH_OFFSET = 12'h008;
    localparam logic [11:0] ROUTE_LOW_OFFSET = 12'h00c;

    // Values after reset.
    localparam logic [7:0] PULL_EN_RESET = 8'hff;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [7:0] ROUTE_HIGH_RESET = 8'h00;
    localparam logic [3:0] ROUTE_LOW_RESET = 4'h0;

    // Channel counts and field positions.
    localparam int unsigned PWM_CHANNELS = 8;
    localparam int unsigned PORT_PINS = 8;
    localparam int unsigned HIGH_FIRST_CH = 4;
    localparam int unsigned HIGH_SEL_W = 2;

    // Port S pin that each channel reaches, three bits per channel.
    localparam logic [23:0] S_PIN_MAP = {
        3'h1, 3'h0, 3'h3, 3'h2, 3'h7, 3'h6, 3'h5, 3'h4
    };

    typedef enum logic [1:0] {
        ROUTE_PORT_P = 2'h0,
        ROUTE_PORT_S = 2'h1,
        ROUTE_PORT_V = 2'h2,
        ROUTE_PORT_M = 2'h3
    } route_port_t;

endpackage

// File: pwm_router.sv
// Steers each PWM channel to exactly one of its candidate port pins.
`timescale 1ns/1ps
`default_nettype none
module pwm_router
    import pin_route_pkg::*;
(
    input wire logic [7:0] route_high,
    input wire logic [3:0] route_low,
    input wire logic [7:0] pwm_out,
    input wire logic [7:0] pwm_en,
    output logic [7:0] p_en,
    output logic [7:0] p_val,
    output logic [7:0] s_en,
    output logic [7:0] s_val,
    output logic [3:0] v_en,
    output logic [3:0] v_val,
    output logic [3:0] m_en,
    output logic [3:0] m_val
);
    genvar g;
    generate
        for (g = 0; g < PWM_CHANNELS; g++) begin : gen_ch
            route_port_t sel;
            if (g < HIGH_FIRST_CH) begin : gen_low
                // Low channels only choose between port P and port S.
                assign sel = route_port_t'({1'b0, route_low[g]}); // see RL8
            end else begin : gen_high
                assign sel = route_port_t'(
                    route_high[HIGH_SEL_W*(g-HIGH_FIRST_CH) +: HIGH_SEL_W]
                ); // see RL7
                assign v_en[g-HIGH_FIRST_CH] = pwm_en[g] &&
                    (sel == ROUTE_PORT_V); // see RL11
                assign v_val[g-HIGH_FIRST_CH] = pwm_out[g];
                assign m_en[g-HIGH_FIRST_CH] = pwm_en[g] &&
                    (sel == ROUTE_PORT_M); // see RL11
                assign m_val[g-HIGH_FIRST_CH] = pwm_out[g];
            end
            // A channel claims only the pin its selector names.
            assign p_en[g] = pwm_en[g] && (sel == ROUTE_PORT_P); // see RL11
            assign p_val[g] = pwm_out[g];
            assign s_en[S_PIN_MAP[3*g +: 3]] = pwm_en[g] &&
                (sel == ROUTE_PORT_S); // see RL6
            assign s_val[S_PIN_MAP[3*g +: 3]] = pwm_out[g];
        end
    endgenerate
endmodule
`default_nettype wire

// File: pull_control.sv
// Per-pin pull device and interrupt edge selection for port P.
`timescale 1ns/1ps
`default_nettype none
module pull_control
    import pin_route_pkg::*;
(
    input wire logic [7:0] pull_enable_bits,
    input wire logic [7:0] pull_polarity_bits,
    input wire logic [7:0] pin_is_input,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_down_en,
    output logic [7:0] edge_rising_sel
);
    genvar g;
    generate
        for (g = 0; g < PORT_PINS; g++) begin : gen_pin
            logic active;
            // An output pin never gets a pull, whatever the enable holds.
            assign active = pull_enable_bits[g] && pin_is_input[g]; // see RL2
            assign pull_down_en[g] = active && pull_polarity_bits[g]; // see RL4
            assign pull_up_en[g] = active && !pull_polarity_bits[g]; // see RL1
            // Pull-down pairs with a rising active edge, pull-up with falling.
            assign edge_rising_sel[g] = pull_polarity_bits[g]; // see RL5
        end
    endgenerate
endmodule
`default_nettype wire

// File: port_pull_and_pwm_routing.sv
// Port P pull configuration and PWM pin routing with an APB register file.
//
// Contract
// RL1: Pull enable bit turns on input pull.
// RL2: Pull enable ignored while pin is output.
// RL3: All pull enables set after reset.
// RL4: Polarity one pulls down, zero pulls up.
// RL5: Polarity bit also picks interrupt edge.
// RL6: Both routing registers place PWM channels.
// RL7: High register: two-bit port per channel.
// RL8: Low register: one bit, P or S.
// RL9: All four registers accessible any time.
// RL10: LCD beats PWM, PWM beats GPIO.
// RL11: PWM drives only its one selected pin.
`timescale 1ns/1ps
`default_nettype none
module port_pull_and_pwm_routing
    import pin_route_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] direction_bits,
    input wire logic [7:0] gpio_p_data,
    input wire logic [7:0] pwm_ch_out,
    input wire logic [7:0] pwm_ch_en,
    input wire logic [7:0] lcd_seg_en,
    input wire logic [7:0] lcd_seg_out,
    output logic [7:0] pad_p_out,
    output logic [7:0] pad_p_oe,
    output logic [7:0] pad_p_lcd_sel,
    output logic [7:0] pad_p_pull_up,
    output logic [7:0] pad_p_pull_down,
    output logic [7:0] irq_edge_rising,
    output logic [7:0] pwm_s_out,
    output logic [7:0] pwm_s_oe,
    output logic [3:0] pwm_v_out,
    output logic [3:0] pwm_v_oe,
    output logic [3:0] pwm_m_out,
    output logic [3:0] pwm_m_oe
);

    logic [7:0] pull_en_ff;
    logic [7:0] polarity_ff;
    logic [7:0] route_high_ff;
    logic [3:0] route_low_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic addr_hit;
    logic setup_phase;
    logic wr_access;

    logic [7:0] route_p_en;
    logic [7:0] route_p_val;
    logic [7:0] route_s_en;
    logic [7:0] route_s_val;
    logic [3:0] route_v_en;
    logic [3:0] route_v_val;
    logic [3:0] route_m_en;
    logic [3:0] route_m_val;

    logic [7:0] pin_is_input;
    logic [7:0] nxt_pad_out;
    logic [7:0] nxt_pad_oe;
    logic [7:0] pull_up_c;
    logic [7:0] pull_down_c;
    logic [7:0] edge_sel_c;

    logic [7:0] pad_p_out_ff;
    logic [7:0] pad_p_oe_ff;
    logic [7:0] pad_p_lcd_ff;
    logic [7:0] pull_up_ff;
    logic [7:0] pull_down_ff;
    logic [7:0] pwm_s_out_ff;
    logic [7:0] pwm_s_oe_ff;
    logic [3:0] pwm_v_out_ff;
    logic [3:0] pwm_v_oe_ff;
    logic [3:0] pwm_m_out_ff;
    logic [3:0] pwm_m_oe_ff;

    // APB slave. The slave never inserts wait states, so software can
    // reach every register at any time.
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite && addr_hit;
    assign pready = 1'b1; // see RL9

    always_comb begin
        addr_hit = 1'b1;
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            PULL_EN_OFFSET: nxt_prdata = {24'h00_0000, pull_en_ff};
            POLARITY_OFFSET: nxt_prdata = {24'h00_0000, polarity_ff};
            ROUTE_HIGH_OFFSET: nxt_prdata = {24'h00_0000, route_high_ff};
            ROUTE_LOW_OFFSET: nxt_prdata = {28'h000_0000, route_low_ff};
            default: addr_hit = 1'b0;
        endcase
    end

    // An unmapped address answers with an error and reads as zero.
    assign pslverr = psel && penable && !addr_hit;

    // Read data is captured in the setup cycle; no register can change
    // before the access cycle because writes land only at its end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_ff <= nxt_prdata; // see RL9
        end
    end
    assign prdata = prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_en_ff <= PULL_EN_RESET; // see RL3
        end else if (wr_access && paddr == PULL_EN_OFFSET) begin
            pull_en_ff <= pwdata[7:0]; // see RL1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polarity_ff <= POLARITY_RESET;
        end else if (wr_access && paddr == POLARITY_OFFSET) begin
            polarity_ff <= pwdata[7:0]; // see RL4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_high_ff <= ROUTE_HIGH_RESET;
        end else if (wr_access && paddr == ROUTE_HIGH_OFFSET) begin
            route_high_ff <= pwdata[7:0]; // see RL7
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_low_ff <= ROUTE_LOW_RESET;
        end else if (wr_access && paddr == ROUTE_LOW_OFFSET) begin
            route_low_ff <= pwdata[3:0]; // see RL8
        end
    end

    pwm_router u_router (
        .route_high(route_high_ff),
        .route_low(route_low_ff),
        .pwm_out(pwm_ch_out),
        .pwm_en(pwm_ch_en),
        .p_en(route_p_en),
        .p_val(route_p_val),
        .s_en(route_s_en),
        .s_val(route_s_val),
        .v_en(route_v_en),
        .v_val(route_v_val),
        .m_en(route_m_en),
        .m_val(route_m_val)
    );

    // Port P pin ownership: LCD first, then a PWM routed here, then GPIO.
    // An LCD pin has its digital buffers disabled entirely.
    always_comb begin
        for (int i = 0; i < PORT_PINS; i++) begin
            if (lcd_seg_en[i]) begin
                nxt_pad_out[i] = lcd_seg_out[i]; // see RL10
                nxt_pad_oe[i] = 1'b0;
                pin_is_input[i] = 1'b0;
            end else if (route_p_en[i]) begin
                nxt_pad_out[i] = route_p_val[i]; // see RL10
                nxt_pad_oe[i] = 1'b1;
                pin_is_input[i] = 1'b0;
            end else begin
                nxt_pad_out[i] = gpio_p_data[i];
                nxt_pad_oe[i] = direction_bits[i];
                pin_is_input[i] = !direction_bits[i]; // see RL2
            end
        end
    end

    pull_control u_pull (
        .pull_enable_bits(pull_en_ff),
        .pull_polarity_bits(polarity_ff),
        .pin_is_input(pin_is_input),
        .pull_up_en(pull_up_c),
        .pull_down_en(pull_down_c),
        .edge_rising_sel(edge_sel_c)
    );
    assign irq_edge_rising = edge_sel_c; // see RL5

    // Pad controls are registered so the pads see glitch-free levels;
    // the cost is one cycle of latency after a change.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_p_out_ff <= 8'h00;
            pad_p_oe_ff <= 8'h00;
            pad_p_lcd_ff <= 8'h00;
        end else begin
            pad_p_out_ff <= nxt_pad_out;
            pad_p_oe_ff <= nxt_pad_oe;
            pad_p_lcd_ff <= lcd_seg_en; // see RL10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_ff <= 8'h00;
            pull_down_ff <= 8'h00;
        end else begin
            pull_up_ff <= pull_up_c; // see RL1
            pull_down_ff <= pull_down_c; // see RL4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_s_out_ff <= 8'h00;
            pwm_s_oe_ff <= 8'h00;
            pwm_v_out_ff <= 4'h0;
            pwm_v_oe_ff <= 4'h0;
            pwm_m_out_ff <= 4'h0;
            pwm_m_oe_ff <= 4'h0;
        end else begin
            pwm_s_out_ff <= route_s_val;
            pwm_s_oe_ff <= route_s_en; // see RL6
            pwm_v_out_ff <= route_v_val;
            pwm_v_oe_ff <= route_v_en;
            pwm_m_out_ff <= route_m_val;
            pwm_m_oe_ff <= route_m_en;
        end
    end

    assign pad_p_out = pad_p_out_ff;
    assign pad_p_oe = pad_p_oe_ff;
    assign pad_p_lcd_sel = pad_p_lcd_ff;
    assign pad_p_pull_up = pull_up_ff;
    assign pad_p_pull_down = pull_down_ff;
    assign pwm_s_out = pwm_s_out_ff;
    assign pwm_s_oe = pwm_s_oe_ff;
    assign pwm_v_out = pwm_v_out_ff;
    assign pwm_v_oe = pwm_v_oe_ff;
    assign pwm_m_out = pwm_m_out_ff;
    assign pwm_m_oe = pwm_m_oe_ff;

    a_pull_on_input: assert property ( // see RL1
        @(posedge pclk) disable iff (!presetn)
        (pull_en_ff[0] && !polarity_ff[0] && pin_is_input[0])
            ##1 presetn |-> pad_p_pull_up[0] && !pad_p_pull_down[0]
    ) else $error("input pin lacks its pull-up");

    a_output_no_pull: assert property ( // see RL2
        @(posedge pclk) disable iff (!presetn)
        (pad_p_oe & (pad_p_pull_up | pad_p_pull_down)) == 8'h00
    ) else $error("pull device active on a driven pin");

    a_pull_reset_value: assert property ( // see RL3
        @(posedge pclk)
        !presetn |-> pull_en_ff == PULL_EN_RESET
    ) else $error("pull enables not all set in reset");

    a_pull_down_select: assert property ( // see RL4
        @(posedge pclk) disable iff (!presetn)
        (pull_en_ff[5] && polarity_ff[5] && !lcd_seg_en[5] &&
            !route_p_en[5] && !direction_bits[5])
            |=> pad_p_pull_down[5] && !pad_p_pull_up[5]
    ) else $error("pull-down not applied on pin five");

    a_edge_with_pull: assert property ( // see RL5
        @(posedge pclk) disable iff (!presetn)
        $stable(polarity_ff) |->
            (pad_p_pull_down & ~irq_edge_rising) == 8'h00
    ) else $error("pull-down pin without rising edge select");

    a_high_route_v: assert property ( // see RL7
        @(posedge pclk) disable iff (!presetn)
        (route_high_ff[7:6] == ROUTE_PORT_V && pwm_ch_en[7])
            |=> pwm_v_oe[3] && pwm_v_out[3] == $past(pwm_ch_out[7])
                && !pwm_s_oe[1] && !pwm_m_oe[3]
    ) else $error("channel seven not on port V pin three");

    a_low_route_s: assert property ( // see RL8
        @(posedge pclk) disable iff (!presetn)
        (route_low_ff[3] && pwm_ch_en[3])
            |=> pwm_s_oe[7] && pwm_s_out[7] == $past(pwm_ch_out[3])
    ) else $error("channel three not on port S pin seven");

    a_write_any_time: assert property ( // see RL9
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == ROUTE_HIGH_OFFSET)
            |=> route_high_ff == $past(pwdata[7:0]) ##1
                (route_high_ff == $past(route_high_ff) ||
                 $past(wr_access))
    ) else $error("routing write did not take effect");

    a_read_back: assert property ( // see RL9
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == POLARITY_OFFSET)
            |=> prdata == {24'h00_0000, $past(polarity_ff)}
    ) else $error("polarity read returned a wrong value");

    a_lcd_over_pwm: assert property ( // see RL10
        @(posedge pclk) disable iff (!presetn)
        (lcd_seg_en[0] && pwm_ch_en[0] && !route_low_ff[0])
            |=> pad_p_lcd_sel[0] && !pad_p_oe[0]
                && pad_p_out[0] == $past(lcd_seg_out[0])
    ) else $error("LCD segment lost priority on pin zero");

    a_single_pin: assert property ( // see RL11
        @(posedge pclk) disable iff (!presetn)
        $onehot0({route_p_en[7], route_s_en[1], route_v_en[3],
            route_m_en[3]})
    ) else $error("channel seven drives more than one pin");

    c_route_m: cover property (
        @(posedge pclk) disable iff (!presetn)
        route_high_ff[1:0] == ROUTE_PORT_M && pwm_ch_en[4]
    );

    c_pwm_on_p: cover property (
        @(posedge pclk) disable iff (!presetn)
        route_p_en[2] && !lcd_seg_en[2] && !direction_bits[2]
    );

    c_read_access: cover property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == PULL_EN_OFFSET
    );

    c_pull_down_pin: cover property (
        @(posedge pclk) disable iff (!presetn)
        pad_p_pull_down[0] && irq_edge_rising[0]
    );

    c_lcd_pin: cover property (
        @(posedge pclk) disable iff (!presetn)
        pad_p_lcd_sel[0] && pwm_ch_en[0]
    );

endmodule
`default_nettype wire

// File: pwm_far_side.sv
// Behavioural PWM module that feeds the channel outputs and enables.
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] en_req,
    output logic [7:0] pwm_ch_out,
    output logic [7:0] pwm_ch_en
);
    // An odd step gives each channel its own waveform.
    // A swapped pin map then shows as a wrong value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_ch_out <= 8'h00;
            pwm_ch_en <= 8'h00;
        end else begin
            pwm_ch_out <= pwm_ch_out + 8'h5b;
            pwm_ch_en <= en_req;
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the port pull and PWM routing block.
`timescale 1ns/1ps
`default_nettype none
module tb
    import pin_route_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [7:0] dir = 8'h00, gpio = 8'h00, en_req = 8'h00;
    logic [7:0] lcd_en = 8'h00, lcd_out = 8'h00, prev;
    logic [7:0] pwm_out, pwm_en, p_out, p_oe, p_lcd, p_pu, p_pd, irq_r;
    logic [7:0] s_out, s_oe;
    logic [3:0] v_out, v_oe, m_out, m_oe;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    pwm_far_side pwm_src (.pclk(pclk), .presetn(presetn), .en_req(en_req),
        .pwm_ch_out(pwm_out), .pwm_ch_en(pwm_en));

    port_pull_and_pwm_routing dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .direction_bits(dir), .gpio_p_data(gpio),
        .pwm_ch_out(pwm_out), .pwm_ch_en(pwm_en), .lcd_seg_en(lcd_en),
        .lcd_seg_out(lcd_out), .pad_p_out(p_out), .pad_p_oe(p_oe),
        .pad_p_lcd_sel(p_lcd), .pad_p_pull_up(p_pu),
        .pad_p_pull_down(p_pd), .irq_edge_rising(irq_r),
        .pwm_s_out(s_out), .pwm_s_oe(s_oe), .pwm_v_out(v_out),
        .pwm_v_oe(v_oe), .pwm_m_out(m_out), .pwm_m_oe(m_oe));

    always #50 pclk = ~pclk;

    // Pad outputs lag their inputs by one edge, so keep the old value.
    always @(posedge pclk) begin
        prev <= pwm_out;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic finish_test;
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(err, 1'b0);
    endtask

    // Let the register and then the pad stage update before looking.
    task automatic settle;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pulse_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic t_reset;
        settle();
        chk(p_pu, 8'hff);
        apb(1'b1, PULL_EN_OFFSET, 32'h0);
        rd_chk(PULL_EN_OFFSET, 32'h0);
        pulse_reset();
        rd_chk(PULL_EN_OFFSET, 32'hff);
        rd_chk(POLARITY_OFFSET, {24'h0, POLARITY_RESET});
        rd_chk(ROUTE_HIGH_OFFSET, {24'h0, ROUTE_HIGH_RESET});
        rd_chk(ROUTE_LOW_OFFSET, {28'h0, ROUTE_LOW_RESET});
    endtask

    task automatic t_pull;
        apb(1'b1, PULL_EN_OFFSET, 32'hef);
        apb(1'b1, POLARITY_OFFSET, 32'h33);
        dir <= 8'hc0;
        settle();
        chk(p_pu, 8'h0c);
        chk(p_pd, 8'h23);
        chk(irq_r, 8'h33);
        rd_chk(POLARITY_OFFSET, 32'h33);
        apb(1'b1, PULL_EN_OFFSET, 32'hff);
        apb(1'b1, POLARITY_OFFSET, 32'h0);
        dir <= 8'h00;
    endtask

    task automatic t_route_high;
        logic [3:0] g;
        en_req <= 8'hf0;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ROUTE_HIGH_OFFSET, {24'h0, {4{s[1:0]}}});
            settle();
            chk({p_oe[7:4], s_oe[3:0], v_oe, m_oe}, 16'hf000 >> (4 * s));
            chk({s_oe[7:4], p_pu[7:4]}, (s == 0) ? 8'h00 : 8'h0f);
            case (s)
                0: g = p_out[7:4];
                1: g = {s_out[1], s_out[0], s_out[3], s_out[2]};
                2: g = v_out;
                default: g = m_out;
            endcase
            chk(g, prev[7:4]);
        end
        apb(1'b1, ROUTE_HIGH_OFFSET, 32'h0);
    endtask

    task automatic t_route_low;
        en_req <= 8'h0f;
        apb(1'b1, ROUTE_LOW_OFFSET, 32'hff);
        rd_chk(ROUTE_LOW_OFFSET, 32'h0f);
        settle();
        chk({s_oe, p_oe[3:0]}, 12'hf00);
        chk(s_out[7:4], prev[3:0]);
        apb(1'b1, ROUTE_LOW_OFFSET, 32'h05);
        settle();
        chk({s_oe, p_oe[3:0]}, 12'h50a);
        chk({p_out[3], s_out[6], p_out[1], s_out[4]}, prev[3:0]);
        apb(1'b1, ROUTE_LOW_OFFSET, 32'h0);
    endtask

    task automatic t_priority;
        @(posedge pclk);
        en_req <= 8'h03;
        dir <= 8'h0c;
        gpio <= 8'h0a;
        lcd_en <= 8'h01;
        lcd_out <= 8'h01;
        settle();
        chk({p_oe, p_lcd, p_pu}, 24'h0e01f0);
        chk(p_out[3:0], {2'b10, prev[1], 1'b1});
    endtask

    task automatic t_unmapped;
        logic [11:0] bad [2] = '{12'h010, 12'h001};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, bad[i], 32'hff);
            chk(err, 1'b1);
            apb(1'b0, bad[i], 32'h0);
            chk(err, 1'b1);
            chk(rd, 32'h0);
        end
        rd_chk(PULL_EN_OFFSET, 32'hff);
    endtask

    initial begin
        // A real falling edge makes the asynchronous reset act at once.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pull();
        t_route_high();
        t_route_low();
        t_priority();
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
